// [bench/core_cycle_timing_interlock_tb.sv]
/*
  Self-checking bench for the cycle timing sequencer: a table of instruction
  classes with their expected cycle totals, first data-side kind and multiply m.
  Assumes the coprocessor model in cti_cp_model drives the busy line.
*/
`timescale 1ns/1ps
module core_cycle_timing_interlock_tb;
  import cti_pkg::*;
  typedef struct {
    cti_class_type c; logic pc, sh, nar, fl, dep; logic [15:0] lst; logic [3:0] src, b;
    logic [31:0] op; logic [5:0] t; cti_cyc_type d; logic [2:0] m;
  } cti_row_type;
  logic clk = 1'b0, arst_n = 1'b0, valid = 1'b0, pc, sh, nar, fl, arm = 1'b0, busy;
  cti_class_type cls = CLS_DATA_OP;
  logic [15:0] lst = 16'h0000;
  logic [31:0] op = 32'h0000_0000;
  logic [3:0] src = 4'h0, bw = 4'h0;
  logic [2:0] use_src = 3'h0;
  logic o_ready, o_fetch_en, o_interlock;
  cti_cyc_type o_icyc, o_dcyc;
  logic [2:0] o_mul;
  int mismatches = 0, cmp_count = 0, cycles = 0, n;
  cti_row_type rows[26];
  always #5 clk = ~clk;
  initial begin pc = 0; sh = 0; nar = 0; fl = 0; end
  cti_core_timing dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_EX_VALID(valid), .I_EX_CLASS(cls),
    .I_EX_WRITES_PC(pc), .I_EX_REG_SHIFT(sh), .I_EX_NARROW(nar), .I_EX_FLAGS_ONLY(fl),
    .I_EX_DEST(src), .I_EX_REG_LIST(lst), .I_EX_WORDS(lst[4:0]), .I_EX_MUL_OPERAND(op),
    .I_DEC_VALID(valid), .I_DEC_SRC_USE(use_src), .I_DEC_SRC_A(src), .I_DEC_SRC_B(4'h0),
    .I_DEC_SRC_C(4'h0), .I_CP_BUSY(busy), .O_READY(o_ready), .O_ICYC(o_icyc),
    .O_DCYC(o_dcyc), .O_FETCH_EN(o_fetch_en), .O_INTERLOCK(o_interlock), .O_MUL_COUNT(o_mul));
  cti_cp_model cp_u (.i_clk(clk), .i_arst_n(arst_n), .i_arm(arm), .i_b(bw), .o_busy(busy));
  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // hang guard: whole run is under two hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin mismatches++; end_of_test(); end
  end
  // offer one instruction, then count cycles up to the one that shows ready
  task automatic run(input cti_row_type r);
    cti_cyc_type d;
    cti_cyc_type ic;
    @(negedge clk);
    if (r.b != 4'h0) begin arm = 1; bw = r.b; @(negedge clk); arm = 0; end
    cls = r.c; pc = r.pc; sh = r.sh; nar = r.nar; fl = r.fl; lst = r.lst; src = r.src;
    op = r.op; use_src = {2'b00, r.dep}; valid = 1;
    @(posedge clk);
    @(negedge clk);
    valid = 0;
    n = 1;
    d = o_dcyc;
    ic = o_icyc;
    while (!o_ready && n < 40) begin
      if (o_interlock) chk(o_fetch_en, 0);
      @(negedge clk);
      n++;
    end
    if (o_interlock) chk(o_fetch_en, 0);
    chk(n, r.t);
    if (r.b == 4'h0) chk(d, r.d);
    chk(ic, CYC_S);
    if (r.m != 3'h0) chk(o_mul, r.m);
  endtask
  initial begin
    rows = '{
      '{CLS_DATA_OP, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 1, CYC_I, 0},
      '{CLS_DATA_OP, 0, 1, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 2, CYC_I, 0},
      '{CLS_DATA_OP, 1, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 3, CYC_I, 0},
      '{CLS_DATA_OP, 1, 1, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 4, CYC_I, 0},
      '{CLS_SINGLE_LOAD, 0, 0, 0, 0, 0, 16'h0000, 4'h2, 4'h0, 0, 1, CYC_N, 0},
      '{CLS_SINGLE_LOAD, 0, 0, 0, 0, 1, 16'h0000, 4'h2, 4'h0, 0, 2, CYC_N, 0},
      '{CLS_SINGLE_LOAD, 0, 0, 1, 0, 1, 16'h0000, 4'h2, 4'h0, 0, 3, CYC_N, 0},
      '{CLS_SINGLE_LOAD, 1, 0, 0, 0, 0, 16'h0000, 4'hf, 4'h0, 0, 5, CYC_N, 0},
      '{CLS_BLOCK_LOAD, 0, 0, 0, 0, 0, 16'h0002, 4'h0, 4'h0, 0, 2, CYC_S, 0},
      '{CLS_BLOCK_LOAD, 0, 0, 0, 0, 1, 16'h000e, 4'h1, 4'h0, 0, 3, CYC_N, 0},
      '{CLS_BLOCK_LOAD, 0, 0, 0, 0, 1, 16'h000e, 4'h3, 4'h0, 0, 4, CYC_N, 0},
      '{CLS_BLOCK_LOAD, 1, 0, 0, 0, 0, 16'h8006, 4'h0, 4'h0, 0, 7, CYC_N, 0},
      '{CLS_BLOCK_STORE, 0, 0, 0, 0, 0, 16'h000e, 4'h0, 4'h0, 0, 3, CYC_N, 0},
      '{CLS_ATOMIC_SWAP, 0, 0, 1, 0, 1, 16'h0000, 4'h4, 4'h0, 0, 3, CYC_N, 0},
      '{CLS_BRANCH, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 3, CYC_I, 0},
      '{CLS_STATUS_WRITE, 0, 0, 0, 1, 0, 16'h0000, 4'h0, 4'h0, 0, 1, CYC_I, 0},
      '{CLS_STATUS_WRITE, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 3, CYC_I, 0},
      '{CLS_COPROC_TO_CORE, 0, 0, 0, 0, 1, 16'h0000, 4'h5, 4'h0, 0, 2, CYC_I, 0},
      '{CLS_COPROC_DATA_OP, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h2, 0, 3, CYC_I, 0},
      '{CLS_SHORT_MULTIPLY, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 32'hffff_ff80, 3, CYC_I, 1},
      '{CLS_UNSIGNED_LONG_MULTIPLY, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 32'hffff_ff80, 7,
        CYC_I, 4},
      '{CLS_SINGLE_STORE, 0, 0, 0, 0, 0, 16'h0000, 4'h2, 4'h0, 0, 1, CYC_N, 0},
      '{CLS_STATUS_READ, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 1, CYC_I, 0},
      '{CLS_CORE_TO_COPROC, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 0, 1, CYC_C, 0},
      '{CLS_COPROC_MEM, 0, 0, 0, 0, 0, 16'h0003, 4'h0, 4'h1, 0, 4, CYC_N, 0},
      '{CLS_SIGNED_LONG_MULTIPLY, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 32'hffff_8000, 5,
        CYC_I, 2}};
    repeat (20) @(negedge clk);
    // reset values seen before the first issue
    chk({o_ready, o_icyc, o_dcyc, o_fetch_en, o_interlock, o_mul}, {1'b1, CYC_I, CYC_I, 5'h04});
    arst_n = 1;
    foreach (rows[i]) run(rows[i]);
    // unsigned long with a small operand: m from all-zero upper bits
    run('{CLS_UNSIGNED_LONG_MULTIPLY, 0, 0, 0, 0, 0, 16'h0000, 4'h0, 4'h0, 32'h0000_1234, 5,
      CYC_I, 2});
    // reset in mid-instruction: outputs drop to idle at once, then a clean restart
    @(negedge clk);
    cls = CLS_SINGLE_LOAD;
    pc = 1;
    valid = 1;
    @(negedge clk);
    valid = 0;
    @(negedge clk);
    arst_n = 0;
    @(negedge clk);
    chk({o_ready, o_icyc, o_dcyc, o_fetch_en, o_interlock, o_mul}, {1'b1, CYC_I, CYC_I, 5'h04});
    arst_n = 1;
    @(negedge clk);
    chk({o_ready, o_icyc, o_dcyc, o_interlock}, {1'b1, CYC_I, CYC_I, 1'b0});
    run(rows[0]);
    end_of_test();
  end
endmodule

// [bench/cti_cp_model.sv]
/*
  Coprocessor stand-in that holds its busy-wait line for a set count of edges.
  Assumes the bench pulses i_arm for one cycle just before the issue edge.
*/
`timescale 1ns/1ps
module cti_cp_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_arm,
  input wire logic [3:0] i_b,
  output logic o_busy
);
  logic [3:0] cnt_r;
  // busy stays high for exactly b edges, starting at the issue edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 4'h0;
    end else if (i_arm) begin
      cnt_r <= i_b;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign o_busy = (cnt_r != 4'h0);
endmodule

// [verilog/cti_core_timing.sv]
/*
  Cycle timing and interlock sequencer of the five-stage core: per instruction
  class it plays out the fetch-side and data-side cycle kinds, inserts load-use
  interlock cycles, waits out coprocessor busy cycles and reports multiply m.
  Assumes decode and execute fields come from logic on I_CLK and are held
  stable while O_READY is low; the coprocessor busy line is on I_CLK too.
*/
`timescale 1ns/1ps
`include "cti_regs.svh"
module cti_core_timing
  import cti_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_EX_VALID,
  input wire cti_class_type I_EX_CLASS,
  input wire logic I_EX_WRITES_PC,
  input wire logic I_EX_REG_SHIFT,
  input wire logic I_EX_NARROW,
  input wire logic I_EX_FLAGS_ONLY,
  input wire logic [3:0] I_EX_DEST,
  input wire logic [15:0] I_EX_REG_LIST,
  input wire logic [4:0] I_EX_WORDS,
  input wire logic [31:0] I_EX_MUL_OPERAND,
  input wire logic I_DEC_VALID,
  input wire logic [2:0] I_DEC_SRC_USE,
  input wire logic [3:0] I_DEC_SRC_A,
  input wire logic [3:0] I_DEC_SRC_B,
  input wire logic [3:0] I_DEC_SRC_C,
  input wire logic I_CP_BUSY,
  output logic O_READY,
  output cti_cyc_type O_ICYC,
  output cti_cyc_type O_DCYC,
  output logic O_FETCH_EN,
  output logic O_INTERLOCK,
  output logic [2:0] O_MUL_COUNT
);
  cti_state_type state_r, state_nxt;
  cti_class_type cls_r, cls_nxt;
  logic pc_r, pc_nxt;
  logic first_nxt;
  logic [5:0] step_r, step_nxt;
  logic [5:0] tot_r, tot_nxt;
  logic [4:0] n_r, n_nxt;
  logic [1:0] dep_r, dep_nxt;
  logic ready_r, ready_nxt;
  cti_cyc_type icyc_r, icyc_nxt;
  cti_cyc_type dcyc_r, dcyc_nxt;
  logic fetch_r, fetch_nxt;
  logic lock_r, lock_nxt;
  logic [2:0] m_r, m_nxt;
  logic accept;
  logic is_coproc;
  logic [15:0] pend_mask;
  logic hit;
  logic hit_last;
  logic [4:0] reg_count;
  logic [2:0] m_calc;
  logic [1:0] load_dep;
  logic [5:0] load_tot;

  function automatic logic [4:0] count_regs(input logic [15:0] list);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, list[i]};
    end
    return c;
  endfunction

  // classes that end with a pipeline refill after a pc change
  function automatic logic is_refill(input cti_class_type c, input logic pc);
    return (c == CLS_BRANCH) || (pc && (c == CLS_DATA_OP || c == CLS_SINGLE_LOAD ||
           c == CLS_BLOCK_LOAD));
  endfunction

  // fetch side: own fetch first, then idle, refill N then S at the end
  function automatic cti_cyc_type fetch_cyc(input cti_class_type c, input logic pc,
                                            input logic first, input logic [5:0] k,
                                            input logic [5:0] tot);
    if (first) begin
      return CYC_S;
    end else if (is_refill(c, pc) && k == tot - 6'h02) begin
      return CYC_N;
    end else if (is_refill(c, pc) && k == tot - 6'h01) begin
      return CYC_S;
    end
    return CYC_I;
  endfunction

  // data side cycle kind at step k of the post-busy sequence
  function automatic cti_cyc_type data_cyc(input cti_class_type c, input logic [5:0] k,
                                           input logic [5:0] tot, input logic [4:0] n);
    cti_cyc_type d;
    d = CYC_I;
    case (c)
      CLS_SINGLE_LOAD: d = (k == 6'h00) ? CYC_N : CYC_I;
      CLS_SINGLE_STORE: d = CYC_N;
      CLS_BLOCK_LOAD: begin
        if (n <= 5'h01 && tot == `CTI_BLOCK_ONE_CYCLES) begin
          d = (k == 6'h00) ? CYC_S : CYC_I;
        end else if (k == 6'h00) begin
          d = CYC_N;
        end else if (k < {1'b0, n}) begin
          d = CYC_S;
        end
      end
      CLS_BLOCK_STORE: begin
        if (k == 6'h00) begin
          d = CYC_N;
        end else if (n > 5'h01) begin
          d = CYC_S;
        end
      end
      CLS_ATOMIC_SWAP: d = (k < 6'h02) ? CYC_N : CYC_I;
      CLS_COPROC_MEM: d = (k == 6'h00) ? CYC_N : CYC_S;
      CLS_CORE_TO_COPROC, CLS_COPROC_TO_CORE: begin
        d = (k == tot - 6'h01) ? CYC_C : CYC_I;
      end
      default: d = CYC_I;
    endcase
    return d;
  endfunction

  // interlock cycles are the trailing dep cycles of the instruction
  function automatic logic in_lock(input logic [5:0] k, input logic [5:0] tot,
                                   input logic [1:0] dep);
    return (dep != 2'h0) && (k >= tot - {4'h0, dep});
  endfunction

  cti_mul_count u_mul (
    .i_operand(I_EX_MUL_OPERAND),
    .i_unsigned(I_EX_CLASS == CLS_UNSIGNED_LONG_MULTIPLY),
    .o_m(m_calc)
  );

  cti_hazard_check u_hazard (
    .i_dec_valid(I_DEC_VALID),
    .i_src_use(I_DEC_SRC_USE),
    .i_src_a(I_DEC_SRC_A),
    .i_src_b(I_DEC_SRC_B),
    .i_src_c(I_DEC_SRC_C),
    .i_pend_mask(pend_mask),
    .o_hit(hit),
    .o_hit_last(hit_last)
  );

  // issue decode: pending targets, interlock length and total cycles
  always_comb begin
    reg_count = count_regs(I_EX_REG_LIST);
    is_coproc = (I_EX_CLASS == CLS_COPROC_DATA_OP) || (I_EX_CLASS == CLS_COPROC_MEM) ||
                (I_EX_CLASS == CLS_CORE_TO_COPROC) || (I_EX_CLASS == CLS_COPROC_TO_CORE);
    pend_mask = 16'h0000;
    load_dep = 2'h0;
    case (I_EX_CLASS)
      CLS_SINGLE_LOAD, CLS_ATOMIC_SWAP, CLS_COPROC_TO_CORE: begin
        pend_mask = 16'h0001 << I_EX_DEST;
      end
      CLS_BLOCK_LOAD: pend_mask = I_EX_REG_LIST;
      default: pend_mask = 16'h0000;
    endcase
    case (I_EX_CLASS)
      CLS_SINGLE_LOAD: begin
        if (!I_EX_WRITES_PC && hit) begin
          load_dep = I_EX_NARROW ? `CTI_NARROW_LOCK : `CTI_WORD_LOCK;
        end
      end
      CLS_ATOMIC_SWAP: load_dep = (hit && I_EX_NARROW) ? `CTI_WORD_LOCK : 2'h0;
      CLS_BLOCK_LOAD: begin
        // a hit on an earlier register needs no stall: it is ready by the last access
        load_dep = (!I_EX_WRITES_PC && hit_last) ? `CTI_WORD_LOCK : 2'h0;
      end
      CLS_COPROC_TO_CORE: begin
        load_dep = (!I_EX_WRITES_PC && hit) ? `CTI_WORD_LOCK : 2'h0;
      end
      default: load_dep = 2'h0;
    endcase
    load_tot = `CTI_ONE_CYCLE;
    case (I_EX_CLASS)
      CLS_DATA_OP: begin
        load_tot = `CTI_ONE_CYCLE + (I_EX_REG_SHIFT ? `CTI_SHIFT_CYCLES : 6'h00) +
                   (I_EX_WRITES_PC ? `CTI_PC_REFILL_EXTRA : 6'h00);
      end
      CLS_SINGLE_LOAD: begin
        load_tot = I_EX_WRITES_PC ? `CTI_LOAD_PC_CYCLES :
                   `CTI_ONE_CYCLE + {4'h0, load_dep};
      end
      CLS_BLOCK_LOAD: begin
        if (I_EX_WRITES_PC) begin
          load_tot = {1'b0, reg_count} + `CTI_BLOCK_PC_EXTRA;
        end else if (reg_count <= 5'h01) begin
          load_tot = `CTI_BLOCK_ONE_CYCLES;
        end else begin
          load_tot = {1'b0, reg_count} + {4'h0, load_dep};
        end
      end
      CLS_BLOCK_STORE: begin
        load_tot = (reg_count <= 5'h01) ? `CTI_BLOCK_ONE_CYCLES : {1'b0, reg_count};
      end
      CLS_ATOMIC_SWAP: load_tot = `CTI_SWAP_CYCLES + {4'h0, load_dep};
      CLS_BRANCH: load_tot = `CTI_REFILL_CYCLES;
      CLS_COPROC_MEM: begin
        load_tot = (I_EX_WORDS == 5'h00) ? `CTI_ONE_CYCLE : {1'b0, I_EX_WORDS};
      end
      CLS_COPROC_TO_CORE: begin
        load_tot = `CTI_ONE_CYCLE + (I_EX_WRITES_PC ? `CTI_CP_PC_EXTRA :
                   {4'h0, load_dep});
      end
      CLS_STATUS_WRITE: begin
        load_tot = I_EX_FLAGS_ONLY ? `CTI_ONE_CYCLE : `CTI_STATUS_FULL_CYCLES;
      end
      CLS_SHORT_MULTIPLY, CLS_SIGNED_LONG_MULTIPLY, CLS_UNSIGNED_LONG_MULTIPLY: begin
        load_tot = ((I_EX_CLASS == CLS_SHORT_MULTIPLY) ? `CTI_SHORT_MUL_BASE :
                   `CTI_LONG_MUL_BASE) + {3'h0, m_calc};
      end
      default: load_tot = `CTI_ONE_CYCLE;
    endcase
  end

  assign accept = I_EX_VALID && ready_r;

  // sequencer next state; a new instruction may start in the last cycle of the old
  always_comb begin
    state_nxt = state_r;
    cls_nxt = cls_r;
    pc_nxt = pc_r;
    first_nxt = 1'b0;
    step_nxt = step_r;
    tot_nxt = tot_r;
    n_nxt = n_r;
    dep_nxt = dep_r;
    m_nxt = m_r;
    if (accept) begin
      cls_nxt = I_EX_CLASS;
      pc_nxt = I_EX_WRITES_PC;
      first_nxt = 1'b1;
      step_nxt = 6'h00;
      tot_nxt = load_tot;
      n_nxt = reg_count;
      dep_nxt = load_dep;
      if (I_EX_CLASS == CLS_SHORT_MULTIPLY || I_EX_CLASS == CLS_SIGNED_LONG_MULTIPLY ||
          I_EX_CLASS == CLS_UNSIGNED_LONG_MULTIPLY) begin
        m_nxt = m_calc;
      end
      state_nxt = (is_coproc && I_CP_BUSY) ? ST_CP_WAIT : ST_RUN;
    end else begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_CP_WAIT: begin
          // each sampled busy cycle costs one internal cycle
          state_nxt = I_CP_BUSY ? ST_CP_WAIT : ST_RUN;
          step_nxt = 6'h00;
        end
        ST_RUN: begin
          if (step_r == tot_r - 6'h01) begin
            state_nxt = ST_IDLE;
          end else begin
            step_nxt = step_r + 6'h01;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // output next values; the bus kinds are those of the cycle being entered
  always_comb begin
    icyc_nxt = CYC_I;
    dcyc_nxt = CYC_I;
    lock_nxt = 1'b0;
    ready_nxt = 1'b0;
    unique case (state_nxt)
      ST_IDLE: ready_nxt = 1'b1;
      ST_CP_WAIT: icyc_nxt = first_nxt ? CYC_S : CYC_I;
      ST_RUN: begin
        icyc_nxt = fetch_cyc(cls_nxt, pc_nxt, first_nxt, step_nxt, tot_nxt);
        dcyc_nxt = data_cyc(cls_nxt, step_nxt, tot_nxt, n_nxt);
        lock_nxt = in_lock(step_nxt, tot_nxt, dep_nxt);
        if (lock_nxt) begin
          icyc_nxt = CYC_I;
          // a register transfer keeps its C cycle last, so the lock falls on that C cycle itself
          if (cls_nxt != CLS_COPROC_TO_CORE) begin
            dcyc_nxt = CYC_I;
          end
        end
        ready_nxt = (step_nxt == tot_nxt - 6'h01);
      end
      default: ready_nxt = 1'b0;
    endcase
    fetch_nxt = (icyc_nxt != CYC_I);
  end

  // sequencer registers
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= ST_IDLE;
      cls_r <= CLS_DATA_OP;
      pc_r <= 1'b0;
      step_r <= 6'h00;
      tot_r <= `CTI_ONE_CYCLE;
      n_r <= 5'h00;
      dep_r <= 2'h0;
      m_r <= `CTI_MUL_FULL;
    end else begin
      state_r <= state_nxt;
      cls_r <= cls_nxt;
      pc_r <= pc_nxt;
      step_r <= step_nxt;
      tot_r <= tot_nxt;
      n_r <= n_nxt;
      dep_r <= dep_nxt;
      m_r <= m_nxt;
    end
  end

  // output registers
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ready_r <= 1'b1;
      icyc_r <= CYC_I;
      dcyc_r <= CYC_I;
      fetch_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      icyc_r <= icyc_nxt;
      dcyc_r <= dcyc_nxt;
      fetch_r <= fetch_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign O_READY = ready_r;
  assign O_ICYC = icyc_r;
  assign O_DCYC = dcyc_r;
  assign O_FETCH_EN = fetch_r;
  assign O_INTERLOCK = lock_r;
  assign O_MUL_COUNT = m_r;

  // checks of the cycle scripts
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_refill;
    (O_ICYC == CYC_I || O_ICYC == CYC_S) ##1 (O_ICYC == CYC_N) ##1
    (O_ICYC == CYC_S && O_READY);
  endsequence

  sequence s_word_lock;
    (O_ICYC == CYC_S && O_DCYC == CYC_N && !O_INTERLOCK) ##1
    (O_ICYC == CYC_I && O_DCYC == CYC_I && O_INTERLOCK);
  endsequence

  property p_dp_one;
    accept && I_EX_CLASS == CLS_DATA_OP && !I_EX_WRITES_PC && !I_EX_REG_SHIFT
      |=> O_ICYC == CYC_S && O_DCYC == CYC_I && O_READY;
  endproperty
  a_dp_one: assert property (p_dp_one) else $error("plain data op not one cycle");

  property p_dp_shift;
    accept && I_EX_CLASS == CLS_DATA_OP && !I_EX_WRITES_PC && I_EX_REG_SHIFT
      |=> !O_READY ##1 (O_ICYC == CYC_I && O_DCYC == CYC_I && O_READY);
  endproperty
  a_dp_shift: assert property (p_dp_shift) else $error("shifted data op not two cycles");

  property p_branch;
    accept && I_EX_CLASS == CLS_BRANCH |=> (O_ICYC == CYC_S) ##0 s_refill;
  endproperty
  a_branch: assert property (p_branch) else $error("branch refill pattern wrong");

  property p_load_lock;
    accept && I_EX_CLASS == CLS_SINGLE_LOAD && !I_EX_WRITES_PC && hit && !I_EX_NARROW
      |=> s_word_lock ##0 O_READY;
  endproperty
  a_load_lock: assert property (p_load_lock) else $error("word load-use lock wrong");

  property p_narrow_lock;
    accept && I_EX_CLASS == CLS_SINGLE_LOAD && !I_EX_WRITES_PC && hit && I_EX_NARROW
      |=> s_word_lock ##1 (O_INTERLOCK && O_READY);
  endproperty
  a_narrow_lock: assert property (p_narrow_lock) else $error("narrow load lock wrong");

  property p_load_pc;
    accept && I_EX_CLASS == CLS_SINGLE_LOAD && I_EX_WRITES_PC
      |=> O_DCYC == CYC_N ##1 (O_DCYC == CYC_I)[*4] ##0 O_ICYC == CYC_S && O_READY;
  endproperty
  a_load_pc: assert property (p_load_pc) else $error("load to pc not five cycles");

  property p_cp_result;
    accept && I_EX_CLASS == CLS_COPROC_TO_CORE && !I_EX_WRITES_PC && hit && !I_CP_BUSY
      |=> O_DCYC == CYC_I ##1 (O_DCYC == CYC_C && O_READY);
  endproperty
  a_cp_result: assert property (p_cp_result) else $error("result transfer C cycle wrong");

  property p_fetch_halt;
    O_INTERLOCK |-> !O_FETCH_EN && O_ICYC == CYC_I;
  endproperty
  a_fetch_halt: assert property (p_fetch_halt) else $error("fetch during interlock");

  property p_store_multi;
    accept && I_EX_CLASS == CLS_BLOCK_STORE && reg_count == 5'h03
      |=> O_DCYC == CYC_N ##1 O_DCYC == CYC_S && O_ICYC == CYC_I ##1
          O_DCYC == CYC_S && O_READY;
  endproperty
  a_store_multi: assert property (p_store_multi) else $error("block store pattern wrong");

  property p_status_flags;
    accept && I_EX_CLASS == CLS_STATUS_WRITE && I_EX_FLAGS_ONLY |=> O_READY;
  endproperty
  a_status_flags: assert property (p_status_flags) else $error("flag write not one cycle");

  property p_mul_short;
    accept && I_EX_CLASS == CLS_SHORT_MULTIPLY && I_EX_MUL_OPERAND[31:8] == 24'hff_ffff
      |=> O_MUL_COUNT == 3'h1 ##2 O_READY;
  endproperty
  a_mul_short: assert property (p_mul_short) else $error("short multiply m wrong");

  property p_mul_unsigned;
    accept && I_EX_CLASS == CLS_UNSIGNED_LONG_MULTIPLY && I_EX_MUL_OPERAND[31]
      |=> O_MUL_COUNT == `CTI_MUL_FULL;
  endproperty
  a_mul_unsigned: assert property (p_mul_unsigned) else $error("unsigned m wrong");
endmodule

// [verilog/cti_hazard_check.sv]
/*
  Load-use hazard compare between decode sources and pending load targets.
  Assumes sources and the pending mask come from logic on the core clock.
*/
`timescale 1ns/1ps
`include "cti_regs.svh"
module cti_hazard_check
  import cti_pkg::*;
(
  input wire logic i_dec_valid,
  input wire logic [2:0] i_src_use,
  input wire logic [3:0] i_src_a,
  input wire logic [3:0] i_src_b,
  input wire logic [3:0] i_src_c,
  input wire logic [15:0] i_pend_mask,
  output logic o_hit,
  output logic o_hit_last
);
  logic [15:0] src_mask;
  logic [15:0] last_mask;

  function automatic logic [15:0] reg_bit(input logic [3:0] r);
    return 16'h0001 << r;
  endfunction

  // block loads fill lowest register first, so the highest set bit lands last
  function automatic logic [15:0] top_bit(input logic [15:0] m);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        t = reg_bit(4'(i));
      end
    end
    return t;
  endfunction

  // only sources the decoded instruction really reads take part
  always_comb begin
    src_mask = 16'h0000;
    if (i_src_use[0]) begin
      src_mask = src_mask | reg_bit(i_src_a);
    end
    if (i_src_use[1]) begin
      src_mask = src_mask | reg_bit(i_src_b);
    end
    if (i_src_use[2]) begin
      src_mask = src_mask | reg_bit(i_src_c);
    end
    last_mask = top_bit(i_pend_mask);
  end

  assign o_hit = i_dec_valid && ((src_mask & i_pend_mask) != 16'h0000);
  assign o_hit_last = i_dec_valid && ((src_mask & last_mask) != 16'h0000);
endmodule

// [verilog/cti_mul_count.sv]
/*
  Multiplier early-termination count m from the multiplier operand.
  Assumes a purely combinational use by the sequencer on the same clock.
*/
`timescale 1ns/1ps
`include "cti_regs.svh"
module cti_mul_count
  import cti_pkg::*;
(
  input wire logic [31:0] i_operand,
  input wire logic i_unsigned,
  output logic [2:0] o_m
);
  logic [2:0] m_calc;

  // a range ends early when it is all zero, or all one for signed forms
  function automatic logic ext_ok(input logic [23:0] bits, input logic uns);
    logic zero;
    logic ones;
    zero = (bits == 24'h00_0000);
    ones = (bits == 24'hff_ffff);
    return zero | (ones & ~uns);
  endfunction

  // widest range first gives the shortest count
  always_comb begin
    m_calc = `CTI_MUL_FULL;
    if (ext_ok(i_operand[31:8], i_unsigned)) begin
      m_calc = 3'h1;
    end else if (ext_ok({8'h00, i_operand[31:16]} | (i_operand[31] && !i_unsigned ?
                 24'hff_0000 : 24'h00_0000), i_unsigned)) begin
      m_calc = 3'h2;
    end else if (ext_ok({16'h0000, i_operand[31:24]} | (i_operand[31] && !i_unsigned ?
                 24'hff_ff00 : 24'h00_0000), i_unsigned)) begin
      m_calc = 3'h3;
    end
  end

  assign o_m = m_calc;
endmodule

// [verilog/cti_pkg.sv]
/*
  Types shared by the cycle timing sequencer: bus cycle kinds,
  instruction classes and sequencer states.
  Assumes nothing of its surroundings.
*/
package cti_pkg;
  typedef enum logic [1:0] {
    CYC_S = 2'h0,
    CYC_N = 2'h1,
    CYC_I = 2'h2,
    CYC_C = 2'h3
  } cti_cyc_type;

  typedef enum logic [3:0] {
    CLS_DATA_OP = 4'h0,
    CLS_SINGLE_LOAD = 4'h1,
    CLS_SINGLE_STORE = 4'h2,
    CLS_BLOCK_LOAD = 4'h3,
    CLS_BLOCK_STORE = 4'h4,
    CLS_ATOMIC_SWAP = 4'h5,
    CLS_BRANCH = 4'h6,
    CLS_COPROC_DATA_OP = 4'h7,
    CLS_COPROC_MEM = 4'h8,
    CLS_CORE_TO_COPROC = 4'h9,
    CLS_COPROC_TO_CORE = 4'ha,
    CLS_STATUS_READ = 4'hb,
    CLS_STATUS_WRITE = 4'hc,
    CLS_SHORT_MULTIPLY = 4'hd,
    CLS_SIGNED_LONG_MULTIPLY = 4'he,
    CLS_UNSIGNED_LONG_MULTIPLY = 4'hf
  } cti_class_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_CP_WAIT = 2'h3
  } cti_state_type;
endpackage

// [verilog/cti_regs.svh]
/*
  Timing constants for the core cycle timing and interlock sequencer:
  cycle counts per instruction class, interlock lengths and register codes.
  Assumes it is included by bare name after the cti_pkg package is compiled.
*/
`ifndef CTI_REGS_SVH
`define CTI_REGS_SVH
// Contract
// - plain data op without pc write: one cycle, fetch S, data side I.
// - data op with register shift: two cycles, fetch S then I, data I I.
// - data op writing pc: three cycles 2S+1N fetch; register shift adds one I.
// - word load not to pc, no dependent successor: one cycle, one N data access.
// - next instruction reads loaded word: one interlock cycle, I on both sides.
// - loaded byte, halfword or unaligned word used next: two interlock cycles.
// - load to pc: five cycles, fetch 2S+2I+1N, data 1N+4I.
// - block load of one register, not pc: two cycles, S then I both sides.
// - block load of n>1 registers without pc: n cycles, 1N then S data.
// - block load including pc: n+4 cycles, four trailing data I cycles.
// - block store of n>1: n cycles, data 1N then S, fetch S then I.
// - atomic swap with loaded byte used next: three cycles, 2N+1I data.
// - coprocessor ops add b busy I cycles; b+1 for ops, b+n for memory.
// - coprocessor-to-core result used next: extra I before the C cycle.
// - status write of flags only completes in one cycle.
// - status write touching other fields: three cycles, S then two I.
// - signed and short multiply: m from sign-extension of upper operand bits.
// - unsigned long multiply: m from all-zero upper operand bits only.
// - during any interlock the fetch side stops fetching.
// - block load moves registers lowest number first, highest last.
// - dependent of a block load waits until its final memory access begins.
// - dependent on the last block-loaded register adds one interlock cycle if n>1 and pc is not loaded.
`define CTI_REG_PC 4'hf
`define CTI_ONE_CYCLE 6'h01
`define CTI_SHIFT_CYCLES 6'h01
`define CTI_PC_REFILL_EXTRA 6'h02
`define CTI_REFILL_CYCLES 6'h03
`define CTI_LOAD_PC_CYCLES 6'h05
`define CTI_BLOCK_PC_EXTRA 6'h04
`define CTI_BLOCK_ONE_CYCLES 6'h02
`define CTI_SWAP_CYCLES 6'h02
`define CTI_STATUS_FULL_CYCLES 6'h03
`define CTI_SHORT_MUL_BASE 6'h02
`define CTI_LONG_MUL_BASE 6'h03
`define CTI_CP_PC_EXTRA 6'h02
`define CTI_WORD_LOCK 2'h1
`define CTI_NARROW_LOCK 2'h2
`define CTI_MUL_FULL 3'h4
`endif
